/* mcalog_regs.svh */
// Overview of operation
// - Internal error logs type code 0000_0100_0000_0000 in bits 15:0.
// - Bus or interconnect error logs type code 0000_1110_0000_1111 in bits 15:0.
// - Reserved bus type patterns are never emitted; only the two codes appear.
// - Detailed model-specific information sits in bits 31:16, meaning set by type.
// - Bits 56:32 hold a correctable event count, zero-extended.
// - Bus error sets bit 16 on request phase parity error.
// - Bus error sets bit 20 on hard-failure response to a local transaction.
// - Bus error sets bit 21 on response field parity error.
// - Bus error sets bit 22 on inbound data parity error.
// - Inclusion error codes 0x0001, 0x0002, 0x000A for cores 0, 1, 2.
// - Write-exclusive codes 0x0003, 0x0004, 0x000B for cores 0, 1, 2.
// - Front side bus inclusion 0x0005, snoop stall 0x0006, write stall 0x0007.
// - Arbitration timeout 0x0008; internal timeout 0x0200 or 0x0300.
// - Protection queue full or disabled-ways overflow logs 0x0400.
// - Quiet-cycle timeout logs 0x0500 and counts as correctable.
// - Correctable outgoing ECC: 0xC002, 0xC004, 0xC008 for cores 0, 1, 2.
// - Uncorrectable outgoing ECC: 0xE002, 0xE004, 0xE008 for cores 0, 1, 2.
// - Bits 63:57 are validity indicators, kept apart from model-specific encoding.
`ifndef MCALOG_REGS_SVH
`define MCALOG_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MCALOG_STATUS_LO_OFS   4'h0
`define MCALOG_STATUS_HI_OFS   4'h4
`define MCALOG_CTRL_OFS        4'h8
`define MCALOG_CNT_OFS         4'hC

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define MCALOG_TYPE_INTERNAL   16'h0400
`define MCALOG_TYPE_BUS        16'h0E0F
`define MCALOG_BIT_REQ_PAR     16
`define MCALOG_BIT_HARD_FAIL   20
`define MCALOG_BIT_RSP_PAR     21
`define MCALOG_BIT_DATA_PAR    22
`define MCALOG_BIT_VALID       63
`define MCALOG_BIT_OVER        62
`define MCALOG_BIT_UC          61
`define MCALOG_BIT_EN          60
`define MCALOG_STATUS_RESET    64'h0000_0000_0000_0000
`define MCALOG_CTRL_RESET      32'h0000_0001

`endif

/* mcalog_pkg.sv */
package mcalog_pkg;

  // Cache bus controller events, one per enumerated code
  typedef enum logic [4:0] {
    MCALOG_EV_INCL_C0, MCALOG_EV_INCL_C1, MCALOG_EV_INCL_C2,
    MCALOG_EV_WEX_C0, MCALOG_EV_WEX_C1, MCALOG_EV_WEX_C2,
    MCALOG_EV_FSB_INCL, MCALOG_EV_FSB_SNOOP, MCALOG_EV_FSB_WSTALL,
    MCALOG_EV_ARB_TMO, MCALOG_EV_INT_TMO_A, MCALOG_EV_INT_TMO_B,
    MCALOG_EV_QUEUE_FULL, MCALOG_EV_QUIET_TMO,
    MCALOG_EV_CECC_C0, MCALOG_EV_CECC_C1, MCALOG_EV_CECC_C2,
    MCALOG_EV_UECC_C0, MCALOG_EV_UECC_C1, MCALOG_EV_UECC_C2
  } mcalog_event_t;

  // Bus error flags from the detecting logic
  typedef struct packed {
    logic dataParity;
    logic respParity;
    logic hardFail;
    logic reqParity;
  } mcalog_bus_flags_t;

  // One cycle report from the detecting logic
  typedef struct packed {
    logic              busValid;
    mcalog_bus_flags_t busFlags;
    logic              intValid;
    mcalog_event_t     intEvent;
  } mcalog_report_t;

  // Encoded result of the encoder
  typedef struct packed {
    logic        valid;
    logic        correctable;
    logic [15:0] specific;
    logic [15:0] errType;
  } mcalog_code_t;

endpackage : mcalog_pkg

/* mcalog_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcalog_regs.svh"

module mcalog_encoder (
  // Report in
  input  wire mcalog_pkg::mcalog_report_t report,
  // Code out
  output var  mcalog_pkg::mcalog_code_t   code
);

  logic [15:0] intCode;
  logic        intCorr;

  always_comb begin
    intCorr = 1'b0;
    unique case (report.intEvent)
      mcalog_pkg::MCALOG_EV_INCL_C0:    intCode = 16'h0001;
      mcalog_pkg::MCALOG_EV_INCL_C1:    intCode = 16'h0002;
      mcalog_pkg::MCALOG_EV_INCL_C2:    intCode = 16'h000A;
      mcalog_pkg::MCALOG_EV_WEX_C0:     intCode = 16'h0003;
      mcalog_pkg::MCALOG_EV_WEX_C1:     intCode = 16'h0004;
      mcalog_pkg::MCALOG_EV_WEX_C2:     intCode = 16'h000B;
      mcalog_pkg::MCALOG_EV_FSB_INCL:   intCode = 16'h0005;
      mcalog_pkg::MCALOG_EV_FSB_SNOOP:  intCode = 16'h0006;
      mcalog_pkg::MCALOG_EV_FSB_WSTALL: intCode = 16'h0007;
      mcalog_pkg::MCALOG_EV_ARB_TMO:    intCode = 16'h0008;
      mcalog_pkg::MCALOG_EV_INT_TMO_A:  intCode = 16'h0200;
      mcalog_pkg::MCALOG_EV_INT_TMO_B:  intCode = 16'h0300;
      mcalog_pkg::MCALOG_EV_QUEUE_FULL: intCode = 16'h0400;
      mcalog_pkg::MCALOG_EV_QUIET_TMO: begin
        intCode = 16'h0500;
        intCorr = 1'b1;
      end
      mcalog_pkg::MCALOG_EV_CECC_C0: begin
        intCode = 16'hC002;
        intCorr = 1'b1;
      end
      mcalog_pkg::MCALOG_EV_CECC_C1: begin
        intCode = 16'hC004;
        intCorr = 1'b1;
      end
      mcalog_pkg::MCALOG_EV_CECC_C2: begin
        intCode = 16'hC008;
        intCorr = 1'b1;
      end
      mcalog_pkg::MCALOG_EV_UECC_C0:    intCode = 16'hE002;
      mcalog_pkg::MCALOG_EV_UECC_C1:    intCode = 16'hE004;
      mcalog_pkg::MCALOG_EV_UECC_C2:    intCode = 16'hE008;
      // Illegal enum codes are dropped, never logged
      default:                          intCode = 16'h0000;
    endcase
  end

  // Bus errors take priority; internal only when a legal code exists
  always_comb begin
    code = '0;
    if (report.busValid) begin
      code.valid   = 1'b1;
      code.errType = `MCALOG_TYPE_BUS;
      code.specific[`MCALOG_BIT_REQ_PAR - 16]   = report.busFlags.reqParity;
      code.specific[`MCALOG_BIT_HARD_FAIL - 16] = report.busFlags.hardFail;
      code.specific[`MCALOG_BIT_RSP_PAR - 16]   = report.busFlags.respParity;
      code.specific[`MCALOG_BIT_DATA_PAR - 16]  = report.busFlags.dataParity;
    end else if (report.intValid && intCode != 16'h0000) begin
      code.valid       = 1'b1;
      code.errType     = `MCALOG_TYPE_INTERNAL;
      code.specific    = intCode;
      code.correctable = intCorr;
    end
  end

endmodule : mcalog_encoder
`default_nettype wire

/* mcalog_logger.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcalog_regs.svh"

module mcalog_logger #(
  parameter int CNT_WIDTH = 15
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // Error report from detecting logic
  input  wire mcalog_pkg::mcalog_report_t  report,
  // Avalon-MM slave
  input  wire logic [3:0]                  avAddress,
  input  wire logic                        avRead,
  input  wire logic                        avWrite,
  input  wire logic [31:0]                 avWriteData,
  input  wire logic [3:0]                  avByteEnable,
  output logic [31:0]                      avReadData,
  output logic                             avWaitRequest,
  output logic [1:0]                       avResponse,
  // Status
  output logic                             errorLogged
);

  // ----------------------------------------
  // Encoder
  // ----------------------------------------
  mcalog_pkg::mcalog_code_t code;

  mcalog_encoder u_encoder (
    .report (report),
    .code   (code)
  );

  // ----------------------------------------
  // Bank status register
  // ----------------------------------------
  logic [63:0]          bankStatus;
  logic [31:0]          ctrl;
  logic [CNT_WIDTH-1:0] corrCount;
  logic [CNT_WIDTH-1:0] corrInc;
  logic                 logEnable;
  logic                 busy;
  logic                 doWrite;
  logic                 doRead;
  logic [31:0]          wrMask;
  logic [63:0]          next_bankStatus;
  logic                 swWriteLo;
  logic                 swWriteHi;

  assign logEnable = ctrl[0];
  assign doWrite   = avWrite && busy;
  assign doRead    = avRead && busy;
  assign swWriteLo = doWrite && avAddress == `MCALOG_STATUS_LO_OFS;
  assign swWriteHi = doWrite && avAddress == `MCALOG_STATUS_HI_OFS;
  // Saturating step shared by the counter and the status field, so both agree at the top
  assign corrInc   = (&corrCount) ? corrCount : corrCount + 1'b1;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wrMask[i*8 +: 8] = {8{avByteEnable[i]}};
    end
  end

  always_comb begin
    next_bankStatus = bankStatus;
    if (swWriteLo) begin
      next_bankStatus[31:0] = (bankStatus[31:0] & ~wrMask) | (avWriteData & wrMask);
    end
    if (swWriteHi) begin
      next_bankStatus[63:32] = (bankStatus[63:32] & ~wrMask) | (avWriteData & wrMask);
    end
    // A hardware event wins over a software write in the same cycle
    if (code.valid && logEnable) begin
      if (next_bankStatus[`MCALOG_BIT_VALID]) begin
        next_bankStatus[`MCALOG_BIT_OVER] = 1'b1;
      end
      if (!next_bankStatus[`MCALOG_BIT_VALID] || !next_bankStatus[`MCALOG_BIT_UC]) begin
        next_bankStatus[15:0]  = code.errType;
        next_bankStatus[31:16] = code.specific;
      end
      next_bankStatus[`MCALOG_BIT_VALID] = 1'b1;
      next_bankStatus[`MCALOG_BIT_UC]    = next_bankStatus[`MCALOG_BIT_UC] | !code.correctable;
      next_bankStatus[`MCALOG_BIT_EN]    = 1'b1;
      next_bankStatus[56:32]             = {{(25 - CNT_WIDTH){1'b0}},
                                            (code.correctable ? corrInc : corrCount)};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bankStatus <= `MCALOG_STATUS_RESET;
    end else begin
      bankStatus <= next_bankStatus;
    end
  end

  // Correctable counter saturates; a high-word status write clears it to zero, whatever data bits 56:32 take, unless a correctable event is logged then
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      corrCount <= '0;
    end else if (code.valid && logEnable && code.correctable) begin
      corrCount <= corrInc;
    end else if (swWriteHi) begin
      corrCount <= CNT_WIDTH'(0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `MCALOG_CTRL_RESET;
    end else if (doWrite && avAddress == `MCALOG_CTRL_OFS) begin
      ctrl <= {31'h0000_0000, avWriteData[0] & avByteEnable[0] | ctrl[0] & !avByteEnable[0]};
    end
  end

  // ----------------------------------------
  // Avalon slave: one wait state per access
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (avRead || avWrite) && !busy;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avWaitRequest <= 1'b1;
    end else begin
      avWaitRequest <= !((avRead || avWrite) && !busy);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avReadData <= 32'h0000_0000;
      avResponse <= 2'b00;
    end else if ((avRead || avWrite) && !busy) begin
      avResponse <= 2'b00;
      avReadData <= 32'h0000_0000;
      unique case (avAddress)
        `MCALOG_STATUS_LO_OFS: avReadData <= bankStatus[31:0];
        `MCALOG_STATUS_HI_OFS: avReadData <= bankStatus[63:32];
        `MCALOG_CTRL_OFS:      avReadData <= ctrl;
        `MCALOG_CNT_OFS:       avReadData <= {{(32 - CNT_WIDTH){1'b0}}, corrCount};
        default:               avResponse <= 2'b11;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      errorLogged <= 1'b0;
    end else begin
      errorLogged <= next_bankStatus[`MCALOG_BIT_VALID];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence busLog;
    code.valid && logEnable && report.busValid;
  endsequence

  sequence intLog;
    code.valid && logEnable && !report.busValid;
  endsequence

  a_bus_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    busLog and ##0 (!swWriteHi && (!bankStatus[`MCALOG_BIT_UC] || !bankStatus[`MCALOG_BIT_VALID]))
    |=> bankStatus[15:0] == 16'h0E0F)
    else $error("bus type code wrong");

  a_int_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    intLog and ##0 (!swWriteHi && !bankStatus[`MCALOG_BIT_VALID]) |=> bankStatus[15:0] == 16'h0400)
    else $error("internal type code wrong");

  a_type_legal: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid |-> code.errType == 16'h0400 || code.errType == 16'h0E0F)
    else $error("reserved type code emitted");

  a_bus_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid && code.errType == 16'h0E0F |-> code.specific[3:1] == 3'b000 && code.specific[15:7] == 9'h000)
    else $error("reserved bus flag set");

  a_req_parity: assert property (@(posedge core_clk) disable iff (!rst_n)
    report.busValid |-> code.specific[0] == report.busFlags.reqParity)
    else $error("request parity flag wrong");

  a_flags_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    report.busValid |-> code.specific[6:4] == {report.busFlags.dataParity, report.busFlags.respParity,
                                               report.busFlags.hardFail})
    else $error("bus flag bits wrong");

  a_quiet_correct: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid && code.specific == 16'h0500 && code.errType == 16'h0400 |-> code.correctable)
    else $error("quiet timeout not correctable");

  a_uecc_uncorr: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid && code.errType == 16'h0400 && code.specific[15:13] == 3'b111 |-> !code.correctable)
    else $error("uncorrectable ECC marked correctable");

  a_valid_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid && logEnable |=> bankStatus[`MCALOG_BIT_VALID] ##1 errorLogged)
    else $error("valid bit not set after log");

  a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    code.valid && logEnable && code.correctable && corrCount == CNT_WIDTH'(0) && !swWriteHi
    |=> corrCount == CNT_WIDTH'(1) && bankStatus[32])
    else $error("correctable count not stepped");

endmodule : mcalog_logger
`default_nettype wire

/* mcalog_logger_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act, exp) begin testsRun++; if ((act) !== (exp)) begin failCount++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end

module mcalog_logger_test;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic                       core_clk;
  logic                       rst_n;
  mcalog_pkg::mcalog_report_t report;
  logic [3:0]                 avAddress;
  logic                       avRead;
  logic                       avWrite;
  logic [31:0]                avWriteData;
  logic [3:0]                 avByteEnable;
  logic [31:0]                avReadData;
  logic                       avWaitRequest;
  logic [1:0]                 avResponse;
  logic                       errorLogged;
  int                         failCount;
  int                         testsRun;
  logic [33:0]                expQ[$];
  logic [33:0]                mskQ[$];
  mcalog_pkg::mcalog_report_t r;
  logic [16:0]                ev;
  logic [3:0]                 f;
  logic [33:0]                gotV;
  logic [33:0]                expV;

  mcalog_logger u_mcalog_logger (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .report       (report),
    .avAddress    (avAddress),
    .avRead       (avRead),
    .avWrite      (avWrite),
    .avWriteData  (avWriteData),
    .avByteEnable (avByteEnable),
    .avReadData   (avReadData),
    .avWaitRequest(avWaitRequest),
    .avResponse   (avResponse),
    .errorLogged  (errorLogged)
  );

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avAddress   <= a;
    avRead      <= ~wr;
    avWrite     <= wr;
    avWriteData <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 50);
    avRead  <= 1'b0;
    avWrite <= 1'b0;
    if (n >= 50) begin
      failCount++;
      summarize();
    end
  endtask : access

  task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m = {34{1'b1}});
    expQ.push_back(e & m);
    mskQ.push_back(m);
    access(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic clr;
    access(1'b1, 4'h0, 32'h0000_0000);
    access(1'b1, 4'h4, 32'h0000_0000);
  endtask : clr

  task automatic pulse(input mcalog_pkg::mcalog_report_t p);
    @(posedge core_clk);
    report <= p;
    @(posedge core_clk);
    report <= '0;
    repeat (2) @(posedge core_clk);
  endtask : pulse

  // Correctable flag and enumerated code of each controller event
  function automatic logic [16:0] expCode(input int i);
    case (i)
      0:       return {1'b0, 16'h0001};
      1:       return {1'b0, 16'h0002};
      2:       return {1'b0, 16'h000A};
      3:       return {1'b0, 16'h0003};
      4:       return {1'b0, 16'h0004};
      5:       return {1'b0, 16'h000B};
      6:       return {1'b0, 16'h0005};
      7:       return {1'b0, 16'h0006};
      8:       return {1'b0, 16'h0007};
      9:       return {1'b0, 16'h0008};
      10:      return {1'b0, 16'h0200};
      11:      return {1'b0, 16'h0300};
      12:      return {1'b0, 16'h0400};
      13:      return {1'b1, 16'h0500};
      14:      return {1'b1, 16'hC002};
      15:      return {1'b1, 16'hC004};
      16:      return {1'b1, 16'hC008};
      17:      return {1'b0, 16'hE002};
      18:      return {1'b0, 16'hE004};
      default: return {1'b0, 16'hE008};
    endcase
  endfunction : expCode

  // Read results are compared in arrival order
  always @(posedge core_clk) begin
    if (avRead === 1'b1 && avWaitRequest === 1'b0) begin
      if (expQ.size() == 0) begin
        failCount++;
        $display("unexpected read at %0t: got %h expected %h", $time, avReadData, 32'h0);
      end else begin
        gotV = {avResponse, avReadData} & mskQ.pop_front();
        expV = expQ.pop_front();
        `CHECK(gotV, expV)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    failCount++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    failCount = 0;
    testsRun = 0;
    rst_n = 1'b0;
    report = '0;
    avAddress = 4'h0;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWriteData = 32'h0000_0000;
    avByteEnable = 4'hF;
    void'($urandom(11));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(4'h0, 34'h0_0000_0000);
    rd(4'h4, 34'h0_0000_0000);
    rd(4'h8, 34'h0_0000_0001);
    access(1'b1, 4'h2, 32'h0000_0000);
    rd(4'h8, 34'h0_0000_0001);
    rd(4'h2, {2'b11, 32'h0000_0000});
    $display("test reset and decode done");
    for (int i = 0; i < 20; i++) begin
      ev = expCode(i);
      r = '0;
      r.intValid = 1'b1;
      r.intEvent = mcalog_pkg::mcalog_event_t'(i);
      pulse(r);
      `CHECK(errorLogged, 1'b1)
      rd(4'h0, {2'b00, ev[15:0], 16'h0400});
      rd(4'h4, {2'b00, 2'b10, ~ev[16], 14'h0, 15'(ev[16])}, {2'b11, 32'hE000_7FFF});
      rd(4'hC, {2'b00, 17'h0_0000, 15'(ev[16])});
      clr();
    end
    $display("test controller codes done");
    for (int i = 0; i < 10; i++) begin
      f = (i < 4) ? 4'(1 << i) : 4'($urandom);
      r = '0;
      r.busValid = 1'b1;
      r.busFlags = f;
      pulse(r);
      rd(4'h0, {2'b00, 9'h000, f[3], f[2], f[1], 3'b000, f[0], 16'h0E0F});
      clr();
    end
    $display("test bus flags done");
    r = '0;
    r.intValid = 1'b1;
    r.intEvent = mcalog_pkg::mcalog_event_t'(5'h14 + 5'($urandom % 12));
    pulse(r);
    `CHECK(errorLogged, 1'b0)
    rd(4'h4, 34'h0_0000_0000, {2'b11, 32'h8000_0000});
    $display("test illegal code done");
    r = '0;
    r.busValid = 1'b1;
    r.busFlags = 4'h1;
    r.intValid = 1'b1;
    r.intEvent = mcalog_pkg::MCALOG_EV_ARB_TMO;
    pulse(r);
    r.busValid = 1'b0;
    pulse(r);
    rd(4'h0, {2'b00, 16'h0001, 16'h0E0F});
    rd(4'h4, {2'b00, 3'b111, 29'h0}, {2'b11, 32'hE000_0000});
    clr();
    $display("test bus priority done");
    access(1'b1, 4'h8, 32'h0000_0000);
    pulse(r);
    rd(4'h0, 34'h0_0000_0000);
    access(1'b1, 4'h8, 32'h0000_0001);
    pulse(r);
    rd(4'h0, {2'b00, 16'h0008, 16'h0400});
    $display("test logging enable done");
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule : mcalog_logger_test

`default_nettype wire
